// ### bsf_alu_if.sv
interface bsf_alu_if;
  bsf_pkg::bsf_op_t op;
  logic [7:0] operand;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;

  modport core (output op, output operand, output carry_in, input result, input carry_out);
  modport alu (input op, input operand, input carry_in, output result, output carry_out);
endinterface : bsf_alu_if

// ### bsf_core.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
module bsf_core #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_busy,
  output logic [7:0] o_io_data
);

  typedef struct packed {
    bsf_pkg::bsf_state_t st_r;
    logic [7:0] wreg_r;
    logic [7:0] io_r;
    logic [7:0] status_r;
    logic [7:0] prdata_r;
    logic rdy_r;
    logic set_r;
    logic [2:0] sel_r;
  } bsf_regs_t;

  bsf_regs_t r;
  bsf_regs_t nx;
  bsf_alu_if alu ();

  logic acc_go;
  logic wr_go;
  logic cmd_go;
  logic hit_cmd;
  logic hit_wreg;
  logic hit_io;
  logic hit_status;
  logic hit_stat;
  logic unmapped;
  logic [7:0] rd_mux;
  bsf_pkg::bsf_op_t cmd_op;
  logic [2:0] cmd_sel;
  logic [7:0] sel_mask;

  bsf_shift_unit u_shift (
    .a(alu.alu)
  );

  assign cmd_op = bsf_pkg::bsf_op_t'(i_pwdata[bsf_pkg::CMD_OP_LSB +: bsf_pkg::CMD_OP_W]);
  assign cmd_sel = i_pwdata[bsf_pkg::CMD_SEL_LSB +: bsf_pkg::CMD_SEL_W];
  assign sel_mask = 8'h01 << cmd_sel;

  assign alu.op = cmd_op;
  assign alu.operand = r.wreg_r;
  assign alu.carry_in = r.status_r[bsf_pkg::FLAG_C];

  assign hit_cmd = (i_paddr == ADDR_W'(bsf_pkg::OFF_CMD));
  assign hit_wreg = (i_paddr == ADDR_W'(bsf_pkg::OFF_WREG));
  assign hit_io = (i_paddr == ADDR_W'(bsf_pkg::OFF_IO));
  assign hit_status = (i_paddr == ADDR_W'(bsf_pkg::OFF_STATUS_REGISTER));
  assign hit_stat = (i_paddr == ADDR_W'(bsf_pkg::OFF_STAT));
  assign unmapped = !(hit_cmd || hit_wreg || hit_io || hit_status || hit_stat);

  // ready only after a setup cycle seen while idle, so read data is current
  assign o_pready = i_penable && r.rdy_r;
  assign acc_go = i_psel && i_penable && o_pready;
  assign wr_go = acc_go && i_pwrite;
  assign cmd_go = wr_go && hit_cmd;
  assign o_pslverr = acc_go && unmapped;
  assign o_prdata = {24'h000000, r.prdata_r};
  assign o_busy = (r.st_r == bsf_pkg::st_iobit);
  assign o_io_data = r.io_r;

  always_comb begin
    if (hit_wreg) begin
      rd_mux = r.wreg_r;
    end else if (hit_io) begin
      rd_mux = r.io_r;
    end else if (hit_status) begin
      rd_mux = r.status_r;
    end else if (hit_stat) begin
      rd_mux = {7'h00, o_busy};
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_comb begin
    nx = r;
    nx.prdata_r = rd_mux;
    nx.rdy_r = i_psel && !acc_go && (r.st_r == bsf_pkg::st_idle);
    case (r.st_r)
      bsf_pkg::st_idle: begin
        if (cmd_go) begin
          case (cmd_op)
            bsf_pkg::io_bit_set_op, bsf_pkg::io_bit_clear_op: begin
              // second cycle does the read-modify-write
              nx.st_r = bsf_pkg::st_iobit;
              nx.set_r = (cmd_op == bsf_pkg::io_bit_set_op);
              nx.sel_r = cmd_sel;
            end
            bsf_pkg::shift_left_logical_op, bsf_pkg::shift_right_logical_op,
            bsf_pkg::rotate_left_carry_op, bsf_pkg::rotate_right_carry_op,
            bsf_pkg::shift_right_arith_op: begin
              nx.wreg_r = alu.result;
              nx.status_r[bsf_pkg::FLAG_C] = alu.carry_out;
              nx.status_r[bsf_pkg::FLAG_Z] = (alu.result == 8'h00);
              nx.status_r[bsf_pkg::FLAG_N] = alu.result[7];
              nx.status_r[bsf_pkg::FLAG_V] = alu.result[7] ^ alu.carry_out;
            end
            bsf_pkg::nibble_swap_op: begin
              nx.wreg_r = alu.result;
            end
            bsf_pkg::flag_set_op: begin
              nx.status_r[cmd_sel] = 1'b1;
            end
            bsf_pkg::flag_clear_op: begin
              nx.status_r[cmd_sel] = 1'b0;
            end
            bsf_pkg::bit_to_transfer_flag_op: begin
              nx.status_r[bsf_pkg::FLAG_T] = r.wreg_r[cmd_sel];
            end
            bsf_pkg::transfer_flag_to_bit_op: begin
              nx.wreg_r[cmd_sel] = r.status_r[bsf_pkg::FLAG_T];
            end
            bsf_pkg::carry_set_op: begin
              nx.status_r[bsf_pkg::FLAG_C] = 1'b1;
            end
            bsf_pkg::carry_clear_op: begin
              nx.status_r[bsf_pkg::FLAG_C] = 1'b0;
            end
            bsf_pkg::negative_set_op: begin
              nx.status_r[bsf_pkg::FLAG_N] = 1'b1;
            end
            default: begin
              nx.st_r = bsf_pkg::st_idle;
            end
          endcase
        end else if (wr_go && hit_wreg) begin
          nx.wreg_r = i_pwdata[7:0];
        end else if (wr_go && hit_io) begin
          nx.io_r = i_pwdata[7:0];
        end else if (wr_go && hit_status) begin
          nx.status_r = i_pwdata[7:0];
        end
      end
      bsf_pkg::st_iobit: begin
        nx.io_r[r.sel_r] = r.set_r;
        nx.st_r = bsf_pkg::st_idle;
      end
      default: begin
        nx.st_r = bsf_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r.st_r <= bsf_pkg::st_idle;
      r.wreg_r <= bsf_pkg::WREG_RST;
      r.io_r <= bsf_pkg::IO_RST;
      r.status_r <= bsf_pkg::STATUS_RST;
      r.prdata_r <= 8'h00;
      r.rdy_r <= 1'b0;
      r.set_r <= 1'b0;
      r.sel_r <= 3'h0;
    end else begin
      r <= nx;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  logic is_set;
  logic is_clr;
  logic is_shl;
  logic is_shr;
  logic is_rot_l;
  logic is_rot_r;
  logic is_sra;
  logic is_swap;
  logic is_fset;
  logic is_fclr;
  logic is_tstore;
  logic is_tload;
  logic is_cset;
  logic is_cclr;
  logic is_nset;

  assign is_set = cmd_go && (cmd_op == bsf_pkg::io_bit_set_op);
  assign is_clr = cmd_go && (cmd_op == bsf_pkg::io_bit_clear_op);
  assign is_shl = cmd_go && (cmd_op == bsf_pkg::shift_left_logical_op);
  assign is_shr = cmd_go && (cmd_op == bsf_pkg::shift_right_logical_op);
  assign is_rot_l = cmd_go && (cmd_op == bsf_pkg::rotate_left_carry_op);
  assign is_rot_r = cmd_go && (cmd_op == bsf_pkg::rotate_right_carry_op);
  assign is_sra = cmd_go && (cmd_op == bsf_pkg::shift_right_arith_op);
  assign is_swap = cmd_go && (cmd_op == bsf_pkg::nibble_swap_op);
  assign is_fset = cmd_go && (cmd_op == bsf_pkg::flag_set_op);
  assign is_fclr = cmd_go && (cmd_op == bsf_pkg::flag_clear_op);
  assign is_tstore = cmd_go && (cmd_op == bsf_pkg::bit_to_transfer_flag_op);
  assign is_tload = cmd_go && (cmd_op == bsf_pkg::transfer_flag_to_bit_op);
  assign is_cset = cmd_go && (cmd_op == bsf_pkg::carry_set_op);
  assign is_cclr = cmd_go && (cmd_op == bsf_pkg::carry_clear_op);
  assign is_nset = cmd_go && (cmd_op == bsf_pkg::negative_set_op);

  // first cycle busy with I/O unchanged, second idle
  sequence io_wait_s;
    o_busy && $stable(r.io_r) && !o_pready;
  endsequence

  sequence io_done_s;
    !o_busy && (r.status_r == $past(r.status_r, 2));
  endsequence

  property io_set_p;
    is_set |=> io_wait_s ##1 (io_done_s and (r.io_r == ($past(r.io_r, 2) | $past(sel_mask, 2))));
  endproperty

  property io_clr_p;
    is_clr |=> io_wait_s ##1 (io_done_s and (r.io_r == ($past(r.io_r, 2) & ~$past(sel_mask, 2))));
  endproperty

  property shl_p;
    is_shl |=> !o_busy && (r.wreg_r == {$past(r.wreg_r[6:0]), 1'b0})
      && (r.status_r[bsf_pkg::FLAG_C] == $past(r.wreg_r[7]));
  endproperty

  property shr_p;
    is_shr |=> (r.wreg_r == {1'b0, $past(r.wreg_r[7:1])})
      && (r.status_r[bsf_pkg::FLAG_C] == $past(r.wreg_r[0]));
  endproperty

  property rot_left_p;
    is_rot_l |=> (r.wreg_r == {$past(r.wreg_r[6:0]), $past(r.status_r[bsf_pkg::FLAG_C])})
      && (r.status_r[bsf_pkg::FLAG_C] == $past(r.wreg_r[7]))
      && (r.status_r[bsf_pkg::FLAG_Z] == (r.wreg_r == 8'h00))
      && (r.status_r[bsf_pkg::FLAG_V] == (r.wreg_r[7] ^ r.status_r[bsf_pkg::FLAG_C]));
  endproperty

  property rot_right_p;
    is_rot_r |=> (r.wreg_r == {$past(r.status_r[bsf_pkg::FLAG_C]), $past(r.wreg_r[7:1])})
      && (r.status_r[bsf_pkg::FLAG_C] == $past(r.wreg_r[0]))
      && (r.status_r[bsf_pkg::FLAG_N] == r.wreg_r[7]);
  endproperty

  property arith_p;
    is_sra |=> (r.wreg_r[6:0] == $past(r.wreg_r[7:1])) && (r.wreg_r[7] == $past(r.wreg_r[7]));
  endproperty

  property swap_p;
    is_swap |=> (r.wreg_r == {$past(r.wreg_r[3:0]), $past(r.wreg_r[7:4])}) && $stable(r.status_r);
  endproperty

  property fset_p;
    is_fset |=> (r.status_r == ($past(r.status_r) | $past(sel_mask)));
  endproperty

  property fclr_p;
    is_fclr |=> (r.status_r == ($past(r.status_r) & ~$past(sel_mask)));
  endproperty

  property tstore_p;
    is_tstore |=> (r.status_r[bsf_pkg::FLAG_T] == $past(r.wreg_r[cmd_sel]))
      && (r.status_r[5:0] == $past(r.status_r[5:0]))
      && (r.status_r[7] == $past(r.status_r[7])) && $stable(r.wreg_r);
  endproperty

  property tload_p;
    is_tload |=> (r.wreg_r == (($past(r.wreg_r) & ~$past(sel_mask))
      | ($past(r.status_r[bsf_pkg::FLAG_T]) ? $past(sel_mask) : 8'h00))) && $stable(r.status_r);
  endproperty

  property carry_p;
    (is_cset || is_cclr) |=> (r.status_r[bsf_pkg::FLAG_C] == $past(is_cset))
      && (r.status_r[7:1] == $past(r.status_r[7:1]));
  endproperty

  property neg_p;
    is_nset |=> r.status_r[bsf_pkg::FLAG_N] && (r.status_r[1:0] == $past(r.status_r[1:0]))
      && (r.status_r[7:3] == $past(r.status_r[7:3]));
  endproperty

  // writes to the status word or to no register change nothing
  property wr_ignored_p;
    (wr_go && (hit_stat || unmapped)) |=> $stable(r.wreg_r) && $stable(r.io_r) && $stable(r.status_r);
  endproperty

  property rd_wreg_p;
    (acc_go && !i_pwrite && hit_wreg) |-> (o_prdata == {24'h000000, r.wreg_r});
  endproperty

  property rd_io_p;
    (acc_go && !i_pwrite && hit_io) |-> (o_prdata == {24'h000000, r.io_r});
  endproperty

  property rd_status_p;
    (acc_go && !i_pwrite && hit_status) |-> (o_prdata == {24'h000000, r.status_r});
  endproperty

  // setup in the busy cycle costs one wait state
  property busy_wait_p;
    (o_busy && i_psel && !i_penable) |=> !o_pready;
  endproperty

  io_set_bit_a: assert property (io_set_p) else $error("io bit set wrong");
  io_clr_bit_a: assert property (io_clr_p) else $error("io bit clear wrong");
  shift_left_a: assert property (shl_p) else $error("left shift wrong");
  shift_right_a: assert property (shr_p) else $error("right shift wrong");
  rotate_left_a: assert property (rot_left_p) else $error("rotate left wrong");
  rotate_right_a: assert property (rot_right_p) else $error("rotate right wrong");
  arith_shift_a: assert property (arith_p) else $error("arith shift wrong");
  nibble_swap_a: assert property (swap_p) else $error("nibble swap wrong");
  flag_set_a: assert property (fset_p) else $error("flag set wrong");
  flag_clear_a: assert property (fclr_p) else $error("flag clear wrong");
  bit_store_a: assert property (tstore_p) else $error("bit store wrong");
  bit_load_a: assert property (tload_p) else $error("bit load wrong");
  carry_force_a: assert property (carry_p) else $error("carry force wrong");
  negative_set_a: assert property (neg_p) else $error("negative set wrong");
  write_ignored_a: assert property (wr_ignored_p) else $error("ignored write took effect");
  read_wreg_a: assert property (rd_wreg_p) else $error("working register read stale");
  read_io_a: assert property (rd_io_p) else $error("io register read stale");
  read_status_a: assert property (rd_status_p) else $error("status read stale");
  busy_wait_a: assert property (busy_wait_p) else $error("no wait state in busy cycle");

endmodule : bsf_core

// ### bsf_io_model.sv
module bsf_io_model (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_io_data,
  output logic [7:0] o_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // the io space takes the register value on every core edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_seen <= 8'h00;
    end else begin
      o_seen <= i_io_data;
    end
  end
endmodule : bsf_io_model

// ### bsf_pkg.sv
package bsf_pkg;

  // register map, byte addresses on the APB side
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_WREG = 8'h04;
  localparam logic [7:0] OFF_IO = 8'h08;
  localparam logic [7:0] OFF_STATUS_REGISTER = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;

  // command word layout
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_SEL_LSB = 8;
  localparam int CMD_SEL_W = 3;

  // status register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // cycles from command acceptance to the I/O bit landing
  localparam int IO_BIT_CYCLES = 2;

  typedef enum logic [3:0] {
    nop_op = 4'h0,
    io_bit_set_op = 4'h1,
    io_bit_clear_op = 4'h2,
    shift_left_logical_op = 4'h3,
    shift_right_logical_op = 4'h4,
    rotate_left_carry_op = 4'h5,
    rotate_right_carry_op = 4'h6,
    shift_right_arith_op = 4'h7,
    nibble_swap_op = 4'h8,
    flag_set_op = 4'h9,
    flag_clear_op = 4'hA,
    bit_to_transfer_flag_op = 4'hB,
    transfer_flag_to_bit_op = 4'hC,
    carry_set_op = 4'hD,
    carry_clear_op = 4'hE,
    negative_set_op = 4'hF
  } bsf_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_iobit = 2'b10
  } bsf_state_t;

endpackage : bsf_pkg

// ### bsf_shift_unit.sv
module bsf_shift_unit (
  bsf_alu_if.alu a
);

  always_comb begin
    a.result = a.operand;
    a.carry_out = a.carry_in;
    case (a.op)
      bsf_pkg::shift_left_logical_op: begin
        {a.carry_out, a.result} = {a.operand, 1'b0};
      end
      bsf_pkg::shift_right_logical_op: begin
        {a.result, a.carry_out} = {1'b0, a.operand};
      end
      bsf_pkg::rotate_left_carry_op: begin
        {a.carry_out, a.result} = {a.operand, a.carry_in};
      end
      bsf_pkg::rotate_right_carry_op: begin
        {a.result, a.carry_out} = {a.carry_in, a.operand};
      end
      bsf_pkg::shift_right_arith_op: begin
        // sign bit kept, rest moves down
        {a.result, a.carry_out} = {a.operand[7], a.operand};
      end
      bsf_pkg::nibble_swap_op: begin
        a.result = {a.operand[3:0], a.operand[7:4]};
      end
      default: begin
        a.result = a.operand;
      end
    endcase
  end

endmodule : bsf_shift_unit

// ### tb_bit_shift_flag_ops.sv
module tb_bit_shift_flag_ops;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [7:0] io;
  logic [7:0] seen;
  logic [31:0] q;
  logic e;
  logic [23:0] ex;
  logic [2:0] b;
  logic [7:0] pat [3] = '{8'h81, 8'h80, 8'h4E};
  logic [7:0] spat [3] = '{8'h41, 8'hBE, 8'h00};
  logic chain = 1'b0;
  logic held = 1'b0;
  int nw = 0;
  int miscompares = 0;
  int n_tests = 0;

  always #2.5 clk = ~clk;

  bsf_core #(.ADDR_W(8)) dut_u (
    .i_sys_clk(clk),
    .i_resetn(rstn),
    .i_psel(psel),
    .i_penable(pen),
    .i_pwrite(pwr),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .o_busy(busy),
    .o_io_data(io)
  );

  bsf_io_model io_u (
    .i_sys_clk(clk),
    .i_resetn(rstn),
    .i_io_data(io),
    .o_seen(seen)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // one apb transfer, read data and error land in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // a held select means this setup follows the last access at once
    if (!held) begin
      @(posedge clk);
    end
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
    end
    q = prdata;
    e = pslverr;
    nw = n;
    pen <= 1'b0;
    held = chain;
    if (!chain) begin
      psel <= 1'b0;
    end
  endtask : apb

  // expected {io, wreg, status} after one command
  function automatic logic [23:0] model(input logic [3:0] op, input logic [2:0] b, input logic [7:0] w,
                                        input logic [7:0] s, input logic [7:0] io);
    logic [7:0] r;
    logic c;
    r = w;
    c = s[bsf_pkg::FLAG_C];
    case (op)
      4'h1: io[b] = 1'b1;
      4'h2: io[b] = 1'b0;
      4'h3: {c, r} = {w, 1'b0};
      4'h4: {r, c} = {1'b0, w};
      4'h5: {c, r} = {w, c};
      4'h6: {r, c} = {c, w};
      4'h7: {r, c} = {w[7], w};
      4'h8: r = {w[3:0], w[7:4]};
      4'h9: s[b] = 1'b1;
      4'hA: s[b] = 1'b0;
      4'hB: s[bsf_pkg::FLAG_T] = w[b];
      4'hC: r[b] = s[bsf_pkg::FLAG_T];
      4'hD: s[bsf_pkg::FLAG_C] = 1'b1;
      4'hE: s[bsf_pkg::FLAG_C] = 1'b0;
      4'hF: s[bsf_pkg::FLAG_N] = 1'b1;
      default: r = w;
    endcase
    if (op >= 4'h3 && op <= 4'h7) begin
      s[bsf_pkg::FLAG_C] = c;
      s[bsf_pkg::FLAG_Z] = (r == 8'h00);
      s[bsf_pkg::FLAG_N] = r[7];
      s[bsf_pkg::FLAG_V] = r[7] ^ c;
    end
    return {io, r, s};
  endfunction : model

  initial begin
    #100000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, bsf_pkg::OFF_STAT, 32'h1);
    apb(1'b0, bsf_pkg::OFF_STAT, 32'h0);
    chk(q, 32'h0);
    for (int op = 1; op < 16; op++) begin
      for (int k = 0; k < 3; k++) begin
        b = 3'(op + k);
        apb(1'b1, bsf_pkg::OFF_WREG, {24'h0, pat[k]});
        apb(1'b1, bsf_pkg::OFF_STATUS_REGISTER, {24'h0, spat[k]});
        apb(1'b1, bsf_pkg::OFF_IO, {24'h0, ~pat[k]});
        ex = model(4'(op), b, pat[k], spat[k], ~pat[k]);
        apb(1'b1, bsf_pkg::OFF_CMD, {21'h0, b, 4'h0, 4'(op)});
        if (op < 3) begin
          // second step of the io op: busy up, register not yet written
          #1;
          chk({31'h0, busy}, 32'h1);
          chk({24'h0, io}, {24'h0, ~pat[k]});
          @(posedge clk);
          #1;
          chk({24'h0, io}, {24'h0, ex[23:16]});
          chk({31'h0, busy}, 32'h0);
        end
        apb(1'b0, bsf_pkg::OFF_WREG, 32'h0);
        chk(q, {24'h0, ex[15:8]});
        apb(1'b0, bsf_pkg::OFF_STATUS_REGISTER, 32'h0);
        chk(q, {24'h0, ex[7:0]});
        apb(1'b0, bsf_pkg::OFF_IO, 32'h0);
        chk(q, {24'h0, ex[23:16]});
        chk({24'h0, seen}, {24'h0, ex[23:16]});
      end
    end
    // io set with a read set up in the busy cycle: one wait state, fresh data
    apb(1'b1, bsf_pkg::OFF_IO, 32'h000000F0);
    chain = 1'b1;
    apb(1'b1, bsf_pkg::OFF_CMD, 32'h00000201);
    chain = 1'b0;
    apb(1'b0, bsf_pkg::OFF_IO, 32'h0);
    chk(q, 32'h000000F4);
    chk(32'(nw), 32'h00000002);
    chk({31'h0, e}, 32'h0);
    final_report();
  end
endmodule : tb_bit_shift_flag_ops
